// ===== rtl/i2ctrm_port.sv
// Two-wire slave register port with fuse-backed configuration registers.
`include "i2ctrm_params.svh"

module i2ctrm_port (
    input  wire logic CLK,
    input  wire logic RST,
    input  wire logic SCL_I,
    input  wire logic SDA_I,
    output logic      SDA_O,
    output logic      SDA_OE,
    output logic      PWR_HOLD,
    output logic      REGISTER_ACCESS_UNLOCK
);

    i2ctrm_pkg::i2ctrm_port_t   q;
    i2ctrm_pkg::i2ctrm_port_t   n;
    logic [`I2CTRM_FUSE_W-1:0]  fuse_data;
    logic                       rise;
    logic                       fall;
    logic                       start;
    logic                       stop;
    logic [7:0]                 rd_val;
    logic [4:0]                 wr_idx;
    logic                       fuse_wr_ok;

    // Bit 4 flags a fuse-backed address, bits 3:0 give its slot in the bank.
    function automatic logic [4:0] fuse_index(input logic [7:0] addr);
        logic [4:0] r;
        r = 5'h00;
        if (addr >= `I2CTRM_FUSE_LO0 && addr <= `I2CTRM_FUSE_HI0) begin
            r = {1'b1, 1'b0, addr[2:0]};
        end else if (addr >= `I2CTRM_FUSE_LO1 && addr <= `I2CTRM_FUSE_HI1) begin
            r = {1'b1, `I2CTRM_FUSE_BANK1 + {1'b0, addr[2:0]}};
        end
        return r;
    endfunction

    function automatic logic [7:0] read_byte(input i2ctrm_pkg::i2ctrm_port_t s, input logic [7:0] addr);
        logic [4:0] fi;
        logic [7:0] r;
        fi = fuse_index(addr);
        r  = 8'h00;
        if (fi[4]) begin
            r = s.regs[fi[3:0]];
        end else if (addr == `I2CTRM_SYS_ADDR) begin
            r = {`I2CTRM_VERSION, s.unlock, `I2CTRM_SYS_FIXED, s.hold};
        end else if (addr == `I2CTRM_MODE_ADDR) begin
            r = {6'h00, s.mode};
        end
        return r;
    endfunction

    i2ctrm_fuse u_fuse (
        .clk       (CLK),
        .rst       (RST),
        .store     (q.store),
        .trim_data (q.regs),
        .fuse_data (fuse_data)
    );

    // Edges are taken only from the second and third sampling stages.
    assign rise       = q.scl_s & ~q.scl_p;
    assign fall       = ~q.scl_s & q.scl_p;
    assign start      = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
    assign stop       = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
    assign rd_val     = read_byte(q, q.ptr);
    assign fuse_wr_ok = q.unlock && (q.mode == `I2CTRM_FMODE_WRITE);

    always_comb begin
        wr_idx      = fuse_index(q.ptr);
        n           = q;
        n.store     = 1'b0;
        n.load_pend = 1'b0;
        n.scl_m     = SCL_I;
        n.scl_s     = q.scl_m;
        n.scl_p     = q.scl_s;
        n.sda_m     = SDA_I;
        n.sda_s     = q.sda_m;
        n.sda_p     = q.sda_s;
        if (q.load_pend) begin
            n.regs = fuse_data;
        end
        if (stop) begin
            n.st = i2ctrm_pkg::ST_IDLE;
            n.oe = 1'b0;
        end else if (start) begin
            n.st  = i2ctrm_pkg::ST_ADDR;
            n.cnt = 4'h0;
            n.oe  = 1'b0;
        end else begin
            if (rise && q.cnt != `I2CTRM_BYTE_DONE && q.st != i2ctrm_pkg::ST_IDLE) begin
                n.sh  = {q.sh[6:0], q.sda_s};
                n.cnt = q.cnt + 4'h1;
            end
            case (q.st)
                i2ctrm_pkg::ST_ADDR: begin
                    if (fall && q.cnt == `I2CTRM_BYTE_DONE) begin
                        if (q.sh == `I2CTRM_WRITE_SELECT || q.sh == `I2CTRM_READ_SELECT) begin
                            n.st = i2ctrm_pkg::ST_ADDR_ACK;
                            n.oe = 1'b1;
                            n.rd = q.sh[0];
                        end else begin
                            n.st = i2ctrm_pkg::ST_IDLE;
                        end
                    end
                end
                i2ctrm_pkg::ST_ADDR_ACK: begin
                    if (fall) begin
                        n.cnt = 4'h0;
                        if (q.rd) begin
                            n.st = i2ctrm_pkg::ST_RDATA;
                            n.tx = {rd_val[6:0], 1'b0};
                            n.oe = ~rd_val[7];
                        end else begin
                            n.st = i2ctrm_pkg::ST_PTR;
                            n.oe = 1'b0;
                        end
                    end
                end
                i2ctrm_pkg::ST_PTR: begin
                    if (fall && q.cnt == `I2CTRM_BYTE_DONE) begin
                        n.ptr = q.sh;
                        n.oe  = 1'b1;
                        n.st  = i2ctrm_pkg::ST_PTR_ACK;
                    end
                end
                i2ctrm_pkg::ST_PTR_ACK, i2ctrm_pkg::ST_WDATA_ACK: begin
                    if (fall) begin
                        n.oe  = 1'b0;
                        n.cnt = 4'h0;
                        n.st  = i2ctrm_pkg::ST_WDATA;
                    end
                end
                i2ctrm_pkg::ST_WDATA: begin
                    if (fall && q.cnt == `I2CTRM_BYTE_DONE) begin
                        if (wr_idx[4] && fuse_wr_ok) begin
                            n.regs[wr_idx[3:0]] = q.sh;
                        end
                        if (q.ptr == `I2CTRM_SYS_ADDR) begin
                            n.unlock = q.sh[`I2CTRM_UNLOCK_BIT];
                            n.hold   = q.sh[`I2CTRM_HOLD_BIT];
                        end
                        if (q.ptr == `I2CTRM_MODE_ADDR) begin
                            if (q.unlock) begin
                                n.mode = q.sh[1:0];
                            end
                            n.store     = q.sh[`I2CTRM_STORE_BIT] & fuse_wr_ok;
                            n.load_pend = q.sh[`I2CTRM_LOAD_BIT] & q.unlock;
                        end
                        n.ptr = q.ptr + 8'h01;
                        n.oe  = 1'b1;
                        n.st  = i2ctrm_pkg::ST_WDATA_ACK;
                    end
                end
                i2ctrm_pkg::ST_RDATA: begin
                    if (fall) begin
                        if (q.cnt == `I2CTRM_BYTE_DONE) begin
                            n.oe  = 1'b0;
                            n.ptr = q.ptr + 8'h01;
                            n.st  = i2ctrm_pkg::ST_RDATA_ACK;
                        end else begin
                            n.oe = ~q.tx[7];
                            n.tx = {q.tx[6:0], 1'b0};
                        end
                    end
                end
                i2ctrm_pkg::ST_RDATA_ACK: begin
                    if (rise) begin
                        n.nack = q.sda_s;
                    end
                    if (fall) begin
                        n.cnt = 4'h0;
                        if (q.nack) begin
                            n.st = i2ctrm_pkg::ST_IDLE;
                            n.oe = 1'b0;
                        end else begin
                            n.st = i2ctrm_pkg::ST_RDATA;
                            n.tx = {rd_val[6:0], 1'b0};
                            n.oe = ~rd_val[7];
                        end
                    end
                end
                i2ctrm_pkg::ST_IDLE: begin
                    n.oe = 1'b0;
                end
                default: begin
                    n.st = i2ctrm_pkg::ST_IDLE;
                    n.oe = 1'b0;
                end
            endcase
        end
    end

    // The bus idles high, so the samplers reset to one to avoid a false start.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            q           <= '0;
            q.scl_m     <= 1'b1;
            q.scl_s     <= 1'b1;
            q.scl_p     <= 1'b1;
            q.sda_m     <= 1'b1;
            q.sda_s     <= 1'b1;
            q.sda_p     <= 1'b1;
            q.st        <= i2ctrm_pkg::ST_IDLE;
            q.load_pend <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // Open drain: the pad only ever pulls low.
    assign SDA_O                  = 1'b0;
    assign SDA_OE                 = q.oe;
    assign PWR_HOLD               = q.hold;
    assign REGISTER_ACCESS_UNLOCK = q.unlock;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_addr_done;
        fall && !start && !stop && q.st == i2ctrm_pkg::ST_ADDR && q.cnt == `I2CTRM_BYTE_DONE;
    endsequence

    sequence s_ack_driven;
        q.st == i2ctrm_pkg::ST_ADDR_ACK && q.oe;
    endsequence

    a_write_select: assert property ((s_addr_done ##0 q.sh == `I2CTRM_WRITE_SELECT) |=> s_ack_driven and !q.rd)
        else $error("Write selection not acknowledged.");

    a_read_select: assert property ((s_addr_done ##0 q.sh == `I2CTRM_READ_SELECT) |=> s_ack_driven and q.rd)
        else $error("Read selection not acknowledged.");

    a_foreign_idle: assert property ((s_addr_done ##0 q.sh[7:1] != `I2CTRM_WRITE_SELECT >> 1)
        |=> q.st == i2ctrm_pkg::ST_IDLE && !q.oe)
        else $error("Foreign address was not ignored.");

    a_ptr_advance: assert property ((fall && !stop && !start && q.st == i2ctrm_pkg::ST_WDATA && q.cnt == 4'h8)
        |=> q.ptr == $past(q.ptr) + 8'h01 && q.oe)
        else $error("Pointer did not advance in the acknowledge slot.");

    a_first_byte: assert property ((fall && !stop && !start && q.st == i2ctrm_pkg::ST_ADDR_ACK && q.rd)
        |=> q.oe == ~$past(rd_val[7]) && q.tx == {$past(rd_val[6:0]), 1'b0})
        else $error("First read byte not taken from the pointer.");

    a_nack_release: assert property ((fall && !stop && !start && q.st == i2ctrm_pkg::ST_RDATA_ACK && q.nack)
        |=> !q.oe && q.st == i2ctrm_pkg::ST_IDLE)
        else $error("Data line held after not-acknowledge.");

    a_stop_idle: assert property (stop |=> q.st == i2ctrm_pkg::ST_IDLE ##1 !q.oe)
        else $error("Stop did not return the port to idle.");

    a_locked_write: assert property ((fall && !stop && !start && q.st == i2ctrm_pkg::ST_WDATA && q.cnt == 4'h8
        && !fuse_wr_ok && !q.load_pend) |=> q.regs == $past(q.regs))
        else $error("Fuse-backed register written while locked.");

    a_load_copy: assert property (q.load_pend |=> q.regs == $past(fuse_data))
        else $error("Fuse contents not copied into the registers.");

endmodule

// ===== rtl/i2ctrm_params.svh
// Constants of the two-wire register port with fuse trim.
`ifndef I2CTRM_PARAMS_SVH
`define I2CTRM_PARAMS_SVH

`define I2CTRM_WRITE_SELECT   8'h8E
`define I2CTRM_READ_SELECT    8'h8F
`define I2CTRM_NFUSE          14
`define I2CTRM_FUSE_W         112
`define I2CTRM_FUSE_LO0       8'h10
`define I2CTRM_FUSE_HI0       8'h17
`define I2CTRM_FUSE_LO1       8'h30
`define I2CTRM_FUSE_HI1       8'h35
`define I2CTRM_FUSE_BANK1     4'h8
`define I2CTRM_SYS_ADDR       8'h20
`define I2CTRM_MODE_ADDR      8'h22
`define I2CTRM_UNLOCK_BIT     3
`define I2CTRM_HOLD_BIT       0
`define I2CTRM_STORE_BIT      7
`define I2CTRM_LOAD_BIT       6
`define I2CTRM_FMODE_WRITE    2'h2
`define I2CTRM_SYS_FIXED      2'h3
// Version nibble value is arbitrary.
`define I2CTRM_VERSION        4'h5
// Blank fuse content: only the untrimmed signature at 30h and 31h is set.
`define I2CTRM_FUSE_BLANK     112'h0000_0000_8080_0000_0000_0000_0000
`define I2CTRM_BYTE_DONE      4'h8

`endif

// ===== rtl/i2ctrm_pkg.sv
// Types of the two-wire register port with fuse trim.
`include "i2ctrm_params.svh"

package i2ctrm_pkg;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_PTR,
        ST_PTR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK
    } i2ctrm_state_t;

    typedef struct packed {
        logic                               scl_m;
        logic                               scl_s;
        logic                               scl_p;
        logic                               sda_m;
        logic                               sda_s;
        logic                               sda_p;
        i2ctrm_state_t                      st;
        logic [3:0]                         cnt;
        logic [7:0]                         sh;
        logic [7:0]                         tx;
        logic [7:0]                         ptr;
        logic                               rd;
        logic                               nack;
        logic                               oe;
        logic [`I2CTRM_NFUSE-1:0][7:0]      regs;
        logic                               unlock;
        logic                               hold;
        logic [1:0]                         mode;
        logic                               store;
        logic                               load_pend;
    } i2ctrm_port_t;

    typedef struct packed {
        logic [`I2CTRM_FUSE_W-1:0]          fuse;
    } i2ctrm_fuse_t;

endpackage

// ===== rtl/i2ctrm_fuse.sv
// One-time fuse bank: bits can only go from zero to one.
`include "i2ctrm_params.svh"

module i2ctrm_fuse (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        store,
    input  wire logic [`I2CTRM_FUSE_W-1:0]   trim_data,
    output logic      [`I2CTRM_FUSE_W-1:0]   fuse_data
);

    i2ctrm_pkg::i2ctrm_fuse_t q;
    i2ctrm_pkg::i2ctrm_fuse_t n;

    // Programming ORs in the new image, so a blown bit can never return to zero.
    always_comb begin
        n = q;
        if (store) begin
            n.fuse = q.fuse | trim_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q.fuse <= `I2CTRM_FUSE_BLANK;
        end else begin
            q <= n;
        end
    end

    assign fuse_data = q.fuse;

    a_fuse_sticky: assert property (@(posedge clk) disable iff (rst)
        (($past(q.fuse) & ~q.fuse) == '0))
        else $error("A programmed fuse bit returned to zero.");

    a_store_image: assert property (@(posedge clk) disable iff (rst)
        store |=> (q.fuse == ($past(q.fuse) | $past(trim_data))))
        else $error("Store did not program the register image.");

endmodule

// ===== verification/i2ctrm_master.sv
// Two-wire bus master model that drives the register port from the far side.
module i2ctrm_master #(
    parameter int Q = 25
) (
    input  wire logic clk,
    input  wire logic sda_in,
    output logic      scl,
    output logic      sda
);
    timeunit 1ns;
    timeprecision 1ps;

    // A released line reads high through the pull-up, so sda = 1 means released.
    initial begin
        scl <= 1'b1;
        sda <= 1'b1;
    end

    // A quarter bit of 25 cycles keeps both clock phases at 500 ns and setup at 250 ns.
    task automatic qtr();
        repeat (Q) @(posedge clk);
    endtask

    // Works from an idle bus or, after a byte, as a repeated start.
    task automatic start();
        sda <= 1'b1;
        qtr();
        scl <= 1'b1;
        qtr();
        sda <= 1'b0;
        qtr();
        scl <= 1'b0;
        qtr();
    endtask

    task automatic stop();
        sda <= 1'b0;
        qtr();
        scl <= 1'b1;
        qtr();
        sda <= 1'b1;
        qtr();
    endtask

    // Data changes only while the clock is low; the line is sampled mid high phase.
    task automatic xfer(input logic b, output logic s);
        sda <= b;
        qtr();
        scl <= 1'b1;
        qtr();
        s = sda_in;
        qtr();
        scl <= 1'b0;
        qtr();
    endtask

    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            xfer(d[i], s);
        end
        xfer(1'b1, s);
        ack = ~s;
    endtask

    // Every wanted byte is acknowledged, the last one is not.
    task automatic recv(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            xfer(1'b1, s);
            d[i] = s;
        end
        xfer(last, s);
    endtask
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the two-wire register port.
`include "i2ctrm_params.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk;
    logic       rst;
    logic       scl;
    logic       sda_m;
    logic       sda_o;
    logic       sda_oe;
    logic       pwr_hold;
    logic       unlock;
    logic       sda_wire;
    logic [7:0] dump[$];
    int         bad_count;
    int         checked;

    assign sda_wire = sda_m & ~sda_oe;

    i2ctrm_port dut_u (
        .CLK(clk), .RST(rst), .SCL_I(scl), .SDA_I(sda_wire), .SDA_O(sda_o), .SDA_OE(sda_oe),
        .PWR_HOLD(pwr_hold), .REGISTER_ACCESS_UNLOCK(unlock)
    );
    i2ctrm_master master_u (.clk(clk), .sda_in(sda_wire), .scl(scl), .sda(sda_m));

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data[$]);
        logic ack;
        master_u.start();
        master_u.send(`I2CTRM_WRITE_SELECT, ack);
        chk("write select ack", 8'h01, {7'h00, ack});
        master_u.send(addr, ack);
        chk("pointer ack", 8'h01, {7'h00, ack});
        foreach (data[i]) begin
            master_u.send(data[i], ack);
            chk("data ack", 8'h01, {7'h00, ack});
        end
        master_u.stop();
    endtask

    // With cur set the pointer phase is skipped and the existing pointer is used.
    task automatic rd(input logic cur, input logic [7:0] addr, input logic [7:0] exp[$], inout logic [7:0] got[$]);
        logic       ack;
        logic [7:0] d;
        if (!cur) begin
            master_u.start();
            master_u.send(`I2CTRM_WRITE_SELECT, ack);
            chk("write select ack", 8'h01, {7'h00, ack});
            master_u.send(addr, ack);
            chk("pointer ack", 8'h01, {7'h00, ack});
        end
        master_u.start();
        master_u.send(`I2CTRM_READ_SELECT, ack);
        chk("read select ack", 8'h01, {7'h00, ack});
        foreach (exp[i]) begin
            master_u.recv(i == exp.size() - 1, d);
            got.push_back(d);
            chk("read data", exp[i], d);
        end
        chk("released after nack", 8'h00, {7'h00, sda_oe});
        master_u.stop();
    endtask

    task automatic t_reset();
        chk("oe in reset", 8'h00, {7'h00, sda_oe});
        chk("hold in reset", 8'h00, {7'h00, pwr_hold});
        chk("unlock in reset", 8'h00, {7'h00, unlock});
        chk("open drain value", 8'h00, {7'h00, sda_o});
    endtask

    // The signature is read right after reset; the trim tests that follow run whether or not it is blank.
    task automatic t_signature();
        rd(1'b0, 8'h30, '{8'h80, 8'h80}, dump);
        chk("untrimmed signature", 8'h01, {7'h00, dump[0] === 8'h80 && dump[1] === 8'h80});
    endtask

    task automatic t_system();
        logic [7:0] q[$];
        wr(8'h20, '{8'h09});
        chk("power hold", 8'h01, {7'h00, pwr_hold});
        chk("unlock", 8'h01, {7'h00, unlock});
        rd(1'b0, 8'h20, '{{`I2CTRM_VERSION, 1'b1, `I2CTRM_SYS_FIXED, 1'b1}}, q);
    endtask

    // Fuse-backed writes before mode 10 are acknowledged and dropped.
    task automatic t_locked();
        logic [7:0] q[$];
        wr(8'h10, '{8'hA1, 8'hB2, 8'hC3});
        rd(1'b0, 8'h10, '{8'h00}, q);
    endtask

    task automatic t_page();
        logic [7:0] q[$];
        wr(8'h22, '{8'h02});
        rd(1'b0, 8'h22, '{8'h02}, q);
        wr(8'h10, '{8'hA1, 8'hB2, 8'hC3});
        rd(1'b0, 8'h10, '{8'hA1, 8'hB2, 8'hC3}, q);
        rd(1'b1, 8'h00, '{8'h00}, q);
    endtask

    task automatic t_foreign();
        logic ack;
        master_u.start();
        master_u.send(8'hA0, ack);
        chk("foreign address ack", 8'h00, {7'h00, ack});
        master_u.stop();
    endtask

    // Two store passes: the fuses keep the OR of both images, not the last one.
    // The images never touch the signature bytes, so their set bits must survive the trim.
    task automatic t_store();
        logic [7:0] q[$];
        logic [7:0] sig[$];
        wr(8'h22, '{8'h82});
        wr(8'h10, '{8'h0C});
        wr(8'h22, '{8'h82});
        wr(8'h10, '{8'h00});
        wr(8'h22, '{8'h42});
        rd(1'b0, 8'h10, '{8'hAD, 8'hB2}, q);
        chk("verify against image", 8'hB2, q[1]);
        rd(1'b0, 8'h30, '{8'h80, 8'h80}, sig);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (90000) @(posedge clk);
        bad_count++;
        complete_run();
    end

    initial begin
        rst <= 1'b1;
        bad_count = 0;
        checked = 0;
        repeat (16) @(posedge clk);
        t_reset();
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_signature();
        t_system();
        t_locked();
        t_page();
        t_foreign();
        t_store();
        complete_run();
    end
endmodule
